//--- src/mio_interlock_top.sv
// Overview of operation
// RL1: in-position flag is 1 while any axis position error exceeds the in-position width.
// RL2: global active-low inhibit counts only when selection bit 0 is 0.
// RL3: fast active-low inhibit counts only when selection bit 1 is 1.
// RL4: with selection bit 2 at 0, axis inhibit bit n-1 stops axis n when low.
// RL5: direction inhibits count only when selection bit 3 is 0.
// RL6: global inhibit input is asserted when it reads 0.
// RL7: fast inhibit is bit 6 of the fast input byte, asserted at 0.
// RL8: plus and minus inhibit bytes, bit n-1 per axis n, asserted at 1.
// RL9: override word is high byte over low byte; all-ones and all-zeros mean 0%.
// RL10: override is the inverted word in 0.01% steps; 0xD8EF gives 100.00%.
// RL11: diagnostic item 13 is 1 exactly while the decoded jog override is zero.
// RL12: diagnostic item 14 is 1 while reset, emergency stop or rewind request stands.
// RL13: no jog or automatic motion while the reset state lasts.
// RL14: diagnostic items 12 and 15 report clamp wait and program search.
// RL15: per-axis jog feedrate in mm/min is the base that the override scales.
// RL16: per-axis servo loop gain setting, normal value 3000.
// RL17: diagnostic item 5 is 1 while any enabled interlock holds motion.
// RL18: enabled asserted inhibits stop their axis and direction; release resumes motion.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`default_nettype none
module mio_interlock_top (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic STB_I,
    input wire logic CYC_I,
    output logic ACK_O,
    output logic [31:0] DAT_O,
    output logic IRQ_O,
    input wire logic GLOBAL_MOTION_INHIBIT_N,
    input wire logic [7:0] FAST_INHIBIT_INPUTS,
    input wire logic [7:0] AXIS_MOTION_INHIBIT_N,
    input wire logic [7:0] PLUS_DIRECTION_INHIBIT,
    input wire logic [7:0] MINUS_DIRECTION_INHIBIT,
    input wire logic [7:0] JOG_RATE_SCALE_N_LOW,
    input wire logic [7:0] JOG_RATE_SCALE_N_HIGH,
    input wire logic RESET_REQUEST,
    input wire logic EMERGENCY_STOP_REQUEST,
    input wire logic REWIND_RESET_REQUEST,
    input wire logic CLAMP_WAIT,
    input wire logic PROGRAM_SEARCH_ACTIVE,
    input wire logic [127:0] POS_ERROR,
    output logic [7:0] AXIS_PLUS_ENABLE,
    output logic [7:0] AXIS_MINUS_ENABLE,
    output logic [15:0] JOG_SCALE,
    output logic [31:0] JOG_FEED_PRODUCT,
    output logic [15:0] DIAG_STATUS
);

    function automatic logic [15:0] scale_of(input logic [15:0] w);
        if (w == mio_pkg::SCALE_ALL_ONES || w == mio_pkg::SCALE_ALL_ZEROS) begin
            return mio_pkg::SCALE_ALL_ZEROS;
        end
        return ~w;
    endfunction

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // pin synchroniser; only the second stage is read
    logic [mio_pkg::SYNC_W-1:0] sync1_reg, sync2_reg;
    logic [mio_pkg::SYNC_W-1:0] pins;
    assign pins = {GLOBAL_MOTION_INHIBIT_N, FAST_INHIBIT_INPUTS, AXIS_MOTION_INHIBIT_N,
        PLUS_DIRECTION_INHIBIT, MINUS_DIRECTION_INHIBIT, JOG_RATE_SCALE_N_LOW,
        JOG_RATE_SCALE_N_HIGH, RESET_REQUEST, EMERGENCY_STOP_REQUEST, REWIND_RESET_REQUEST,
        CLAMP_WAIT, PROGRAM_SEARCH_ACTIVE};

    logic global_n;
    logic [7:0] fast_in, axis_n, plus_in, minus_in, jog_lo, jog_hi;
    logic reset_req, estop_req, rewind_req, clamp_in, search_in;
    assign global_n = sync2_reg[53];
    assign fast_in = sync2_reg[52:45];
    assign axis_n = sync2_reg[44:37];
    assign plus_in = sync2_reg[36:29];
    assign minus_in = sync2_reg[28:21];
    assign jog_lo = sync2_reg[20:13];
    assign jog_hi = sync2_reg[12:5];
    assign reset_req = sync2_reg[4];
    assign estop_req = sync2_reg[3];
    assign rewind_req = sync2_reg[2];
    assign clamp_in = sync2_reg[1];
    assign search_in = sync2_reg[0];

    // software state
    logic [7:0] cfg_reg, cfg_next;
    logic [15:0] inpos_reg, inpos_next;
    logic [2:0] axis_sel_reg, axis_sel_next;
    logic [3:0] mask_reg, mask_next;
    logic [3:0] stat_reg, stat_next;
    logic [15:0] feed_reg [mio_pkg::AXES];
    logic [15:0] feed_next [mio_pkg::AXES];
    logic [15:0] gain_reg [mio_pkg::AXES];
    logic [15:0] gain_next [mio_pkg::AXES];
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic irq_reg, irq_next;

    // motion state
    logic [7:0] plus_en_reg, plus_en_next, minus_en_reg, minus_en_next;
    logic [15:0] scale_reg, scale_next;
    logic [31:0] product_reg, product_next;
    logic [15:0] diag_reg, diag_next;

    logic reset_wait, global_hold, any_lock, inpos_wait;
    logic [7:0] axis_hold, plus_hold, minus_hold;
    logic [3:0] events;

    always_comb begin
        reset_wait = reset_req | estop_req | rewind_req; // see RL12
        global_hold = (~cfg_reg[mio_pkg::GLOBAL_LOCK_SELECT] & ~global_n) // see RL2 see RL6
            | (cfg_reg[mio_pkg::FAST_LOCK_SELECT] & ~fast_in[mio_pkg::FAST_INHIBIT_BIT]); // see RL3 see RL7
        axis_hold = cfg_reg[mio_pkg::PER_AXIS_LOCK_SELECT] ? 8'h00 : ~axis_n; // see RL4
        plus_hold = cfg_reg[mio_pkg::DIRECTIONAL_LOCK_SELECT] ? 8'h00 : plus_in; // see RL5 see RL8
        minus_hold = cfg_reg[mio_pkg::DIRECTIONAL_LOCK_SELECT] ? 8'h00 : minus_in;
        // reset state is left out of the interlock flag on purpose
        any_lock = global_hold | (|axis_hold) | (|plus_hold) | (|minus_hold);
        // reset state overrides every other qualification
        if (global_hold || reset_wait) begin // see RL13
            plus_en_next = 8'h00;
            minus_en_next = 8'h00;
        end else begin
            plus_en_next = ~(axis_hold | plus_hold); // see RL18
            minus_en_next = ~(axis_hold | minus_hold);
        end
        scale_next = scale_of({jog_hi, jog_lo}); // see RL9 see RL10
        // base rate times override, in mm/min x 0.01 %; avoids a divider in the loop
        product_next = feed_reg[axis_sel_reg] * scale_reg; // see RL15
        // a single axis outside its window is enough to hold the flag
        inpos_wait = 1'b0;
        for (int i = 0; i < mio_pkg::AXES; i++) begin
            if (POS_ERROR[16*i +: 16] > inpos_reg) begin // see RL1
                inpos_wait = 1'b1;
            end
        end
        diag_next = 16'h0000;
        diag_next[mio_pkg::DIAG_INPOS] = inpos_wait; // see RL1
        diag_next[mio_pkg::DIAG_LOCK] = any_lock; // see RL17
        diag_next[mio_pkg::DIAG_CLAMP] = clamp_in; // see RL14
        diag_next[mio_pkg::DIAG_JOG_ZERO] = (scale_next == mio_pkg::SCALE_ALL_ZEROS); // see RL11
        diag_next[mio_pkg::DIAG_RESET_WAIT] = reset_wait; // see RL12
        diag_next[mio_pkg::DIAG_SEARCH] = search_in; // see RL14
        // events compare the new flag values with the registered ones
        events = 4'h0;
        events[mio_pkg::EV_LOCK] = any_lock & ~diag_reg[mio_pkg::DIAG_LOCK];
        events[mio_pkg::EV_JOG_ZERO] = diag_next[mio_pkg::DIAG_JOG_ZERO] & ~diag_reg[mio_pkg::DIAG_JOG_ZERO];
        events[mio_pkg::EV_RESET_WAIT] = reset_wait & ~diag_reg[mio_pkg::DIAG_RESET_WAIT];
        events[mio_pkg::EV_INPOS_DONE] = ~inpos_wait & diag_reg[mio_pkg::DIAG_INPOS];
    end

    logic req, wr;
    logic [2:0] idx;
    logic [31:0] rd;

    always_comb begin
        req = CYC_I & STB_I;
        // one-cycle ack; a request held past it is answered again two cycles later
        ack_next = req & ~ack_reg;
        // the write lands on the edge where the master samples ack
        wr = req & WE_I & ack_reg;
        idx = ADR_I[4:2];
        cfg_next = cfg_reg;
        inpos_next = inpos_reg;
        axis_sel_next = axis_sel_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        for (int i = 0; i < mio_pkg::AXES; i++) begin
            feed_next[i] = feed_reg[i];
            gain_next[i] = gain_reg[i];
        end
        if (wr) begin
            if (ADR_I == mio_pkg::A_CFG && SEL_I[0]) begin
                cfg_next = DAT_I[7:0];
            end
            if (ADR_I == mio_pkg::A_IMASK && SEL_I[0]) begin
                mask_next = DAT_I[3:0];
            end
            if (ADR_I == mio_pkg::A_ISTAT && SEL_I[0]) begin
                stat_next = stat_reg & ~DAT_I[3:0];
            end
            if (ADR_I == mio_pkg::A_CTRL && SEL_I[0]) begin
                axis_sel_next = DAT_I[2:0];
            end
            if (ADR_I == mio_pkg::A_INPOS) begin
                inpos_next = lane16(inpos_reg, DAT_I, SEL_I);
            end
            if (ADR_I[7:5] == mio_pkg::A_FEED_BLK && ADR_I[1:0] == 2'h0) begin
                feed_next[idx] = lane16(feed_reg[idx], DAT_I, SEL_I); // see RL15
            end
            if (ADR_I[7:5] == mio_pkg::A_GAIN_BLK && ADR_I[1:0] == 2'h0) begin
                gain_next[idx] = lane16(gain_reg[idx], DAT_I, SEL_I); // see RL16
            end
        end
        // a new event wins over a clear in the same cycle
        stat_next = stat_next | events;
        irq_next = |(stat_next & mask_next);
        rd = 32'h0000_0000;
        unique case (ADR_I)
            mio_pkg::A_CFG: rd[7:0] = cfg_reg;
            mio_pkg::A_FAST: rd[7:0] = fast_in;
            mio_pkg::A_AXIS: rd[7:0] = axis_n;
            mio_pkg::A_PLUS: rd[7:0] = plus_in;
            mio_pkg::A_MINUS: rd[7:0] = minus_in;
            mio_pkg::A_JLO: rd[7:0] = jog_lo;
            mio_pkg::A_JHI: rd[7:0] = jog_hi;
            mio_pkg::A_DIAG: rd[15:0] = diag_reg;
            mio_pkg::A_ISTAT: rd[3:0] = stat_reg;
            mio_pkg::A_IMASK: rd[3:0] = mask_reg;
            mio_pkg::A_INPOS: rd[15:0] = inpos_reg;
            mio_pkg::A_CTRL: rd[2:0] = axis_sel_reg;
            mio_pkg::A_SCALE: rd[15:0] = scale_reg;
            default: begin
                if (ADR_I[7:5] == mio_pkg::A_FEED_BLK && ADR_I[1:0] == 2'h0) begin
                    rd[15:0] = feed_reg[idx];
                end else if (ADR_I[7:5] == mio_pkg::A_GAIN_BLK && ADR_I[1:0] == 2'h0) begin
                    rd[15:0] = gain_reg[idx];
                end
            end
        endcase
        // read data stands only with ack, so the bus idles at zero
        dat_next = ack_next ? rd : 32'h0000_0000;
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1_reg <= mio_pkg::SYNC_IDLE;
            sync2_reg <= mio_pkg::SYNC_IDLE;
            cfg_reg <= mio_pkg::CFG_RESET;
            inpos_reg <= mio_pkg::INPOS_RESET;
            axis_sel_reg <= 3'h0;
            mask_reg <= 4'h0;
            stat_reg <= 4'h0;
            for (int i = 0; i < mio_pkg::AXES; i++) begin
                feed_reg[i] <= mio_pkg::FEED_RESET;
                gain_reg[i] <= mio_pkg::GAIN_RESET; // see RL16
            end
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
            plus_en_reg <= 8'h00;
            minus_en_reg <= 8'h00;
            scale_reg <= 16'h0000;
            product_reg <= 32'h0000_0000;
            diag_reg <= 16'h0000;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            cfg_reg <= cfg_next;
            inpos_reg <= inpos_next;
            axis_sel_reg <= axis_sel_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            for (int i = 0; i < mio_pkg::AXES; i++) begin
                feed_reg[i] <= feed_next[i];
                gain_reg[i] <= gain_next[i];
            end
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            irq_reg <= irq_next;
            plus_en_reg <= plus_en_next;
            minus_en_reg <= minus_en_next;
            scale_reg <= scale_next;
            product_reg <= product_next;
            diag_reg <= diag_next;
        end
    end

    assign ACK_O = ack_reg;
    assign DAT_O = dat_reg;
    assign IRQ_O = irq_reg;
    assign AXIS_PLUS_ENABLE = plus_en_reg;
    assign AXIS_MINUS_ENABLE = minus_en_reg;
    assign JOG_SCALE = scale_reg;
    assign JOG_FEED_PRODUCT = product_reg;
    assign DIAG_STATUS = diag_reg;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    // interlock qualification
    a_global_lock_stop: assert property ( // see RL2
        (!cfg_reg[0] && !global_n) |=> (AXIS_PLUS_ENABLE == 8'h00 && AXIS_MINUS_ENABLE == 8'h00))
        else $error("global inhibit did not stop motion");

    a_fast_lock_stop: assert property ( // see RL3
        (cfg_reg[1] && !fast_in[6]) |=> (AXIS_PLUS_ENABLE == 8'h00 && AXIS_MINUS_ENABLE == 8'h00))
        else $error("fast inhibit did not stop motion");

    a_axis_lock_stop: assert property ( // see RL4
        !cfg_reg[2] |=> ((AXIS_PLUS_ENABLE | AXIS_MINUS_ENABLE) & ~$past(axis_n)) == 8'h00)
        else $error("axis inhibit did not stop its axis");

    a_dir_lock_stop: assert property ( // see RL5
        !cfg_reg[3] |=> ((AXIS_PLUS_ENABLE & $past(plus_in)) | (AXIS_MINUS_ENABLE & $past(minus_in))) == 8'h00)
        else $error("direction inhibit did not stop its direction");

    a_reset_state_stop: assert property ( // see RL13
        (reset_req || estop_req || rewind_req) |=> (AXIS_PLUS_ENABLE == 8'h00 && AXIS_MINUS_ENABLE == 8'h00))
        else $error("motion allowed in reset state");

    // outputs still show reset values one edge after release, hence the past reset term
    a_motion_resume: assert property ( // see RL18
        $past(RESETN) && (global_n && fast_in[6] && axis_n == 8'hFF && plus_in == 8'h00 && minus_in == 8'h00
            && !reset_req && !estop_req && !rewind_req) |=> (AXIS_PLUS_ENABLE == 8'hFF && AXIS_MINUS_ENABLE == 8'hFF))
        else $error("motion not resumed after release");

    // jog override decode
    a_scale_unity: assert property ( // see RL10
        ({jog_hi, jog_lo} == 16'hD8EF) |=> JOG_SCALE == mio_pkg::SCALE_UNITY)
        else $error("override word did not decode to 100 percent");

    a_scale_ends_zero: assert property ( // see RL9
        ({jog_hi, jog_lo} == 16'hFFFF || {jog_hi, jog_lo} == 16'h0000) |=> JOG_SCALE == 16'h0000)
        else $error("end override word did not decode to zero");

    a_scale_inverted: assert property ( // see RL10
        ($past(RESETN) && $past({jog_hi, jog_lo}) != 16'hFFFF && $past({jog_hi, jog_lo}) != 16'h0000)
            |-> JOG_SCALE == ~$past({jog_hi, jog_lo}))
        else $error("override word not decoded as its inverse");

    a_jog_zero_flag: assert property ( // see RL11
        $past(RESETN) |-> DIAG_STATUS[13]
            == ($past({jog_hi, jog_lo}) == 16'hFFFF || $past({jog_hi, jog_lo}) == 16'h0000))
        else $error("jog zero flag disagrees with override");

    a_feed_product: assert property ( // see RL15
        $past(RESETN) |-> JOG_FEED_PRODUCT == $past(feed_reg[axis_sel_reg]) * $past(JOG_SCALE))
        else $error("feed product disagrees with feed and override");

    // diagnostic flags
    a_reset_wait_flag: assert property ( // see RL12
        DIAG_STATUS[14] == $past(reset_req || estop_req || rewind_req))
        else $error("reset wait flag disagrees with requests");

    a_inpos_flag: assert property ( // see RL1
        (POS_ERROR[15:0] > inpos_reg || POS_ERROR[31:16] > inpos_reg) |=> DIAG_STATUS[3])
        else $error("in-position wait flag missing");

    a_inpos_clear: assert property ( // see RL1
        (POS_ERROR == 128'h0) |=> !DIAG_STATUS[3])
        else $error("in-position wait flag set with no position error");

    a_clamp_search_flags: assert property ( // see RL14
        DIAG_STATUS[12] == $past(clamp_in) && DIAG_STATUS[15] == $past(search_in))
        else $error("clamp or search flag disagrees with its input");

    a_lock_flag: assert property ( // see RL17
        $fell(AXIS_PLUS_ENABLE[0]) && !$past(reset_wait) |-> DIAG_STATUS[5])
        else $error("interlock flag missing while axis held");

    // register bus
    a_ack_answer: assert property ((CYC_I && STB_I && !ACK_O) |=> ACK_O)
        else $error("request not answered in the next cycle");

    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");

    a_read_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
        else $error("read data driven without ack");

    a_irq_level: assert property (IRQ_O == |(stat_reg & mask_reg))
        else $error("interrupt output disagrees with status and mask");

    c_global_hold: cover property (!cfg_reg[0] && !global_n ##1 AXIS_PLUS_ENABLE == 8'h00);
    c_dir_hold: cover property (!cfg_reg[3] && plus_in[0] ##1 !AXIS_PLUS_ENABLE[0]);
    c_jog_unity: cover property (JOG_SCALE == mio_pkg::SCALE_UNITY);
    c_reset_wait: cover property ($rose(DIAG_STATUS[14]));
    c_irq_raised: cover property ($rose(IRQ_O));

endmodule // mio_interlock_top
`default_nettype wire

//--- src/mio_pkg.sv
`default_nettype none
package mio_pkg;
    localparam int unsigned AXES = 8;
    localparam int unsigned SYNC_W = 54;
    // register byte offsets
    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_FAST = 8'h04;
    localparam logic [7:0] A_AXIS = 8'h08;
    localparam logic [7:0] A_PLUS = 8'h0C;
    localparam logic [7:0] A_MINUS = 8'h10;
    localparam logic [7:0] A_JLO = 8'h14;
    localparam logic [7:0] A_JHI = 8'h18;
    localparam logic [7:0] A_DIAG = 8'h1C;
    localparam logic [7:0] A_ISTAT = 8'h20;
    localparam logic [7:0] A_IMASK = 8'h24;
    localparam logic [7:0] A_INPOS = 8'h28;
    localparam logic [7:0] A_CTRL = 8'h2C;
    localparam logic [7:0] A_SCALE = 8'h30;
    localparam logic [2:0] A_FEED_BLK = 3'h2;
    localparam logic [2:0] A_GAIN_BLK = 3'h3;
    // interlock selection fields
    localparam int unsigned GLOBAL_LOCK_SELECT = 0;
    localparam int unsigned FAST_LOCK_SELECT = 1;
    localparam int unsigned PER_AXIS_LOCK_SELECT = 2;
    localparam int unsigned DIRECTIONAL_LOCK_SELECT = 3;
    localparam int unsigned FAST_INHIBIT_BIT = 6;
    // diagnostic bits, numbered as the diagnostic items
    localparam int unsigned DIAG_INPOS = 3;
    localparam int unsigned DIAG_LOCK = 5;
    localparam int unsigned DIAG_CLAMP = 12;
    localparam int unsigned DIAG_JOG_ZERO = 13;
    localparam int unsigned DIAG_RESET_WAIT = 14;
    localparam int unsigned DIAG_SEARCH = 15;
    // interrupt status bits
    localparam int unsigned EV_LOCK = 0;
    localparam int unsigned EV_JOG_ZERO = 1;
    localparam int unsigned EV_RESET_WAIT = 2;
    localparam int unsigned EV_INPOS_DONE = 3;
    // reset values and jog override decode codes
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] INPOS_RESET = 16'h0010;
    localparam logic [15:0] GAIN_RESET = 16'h0BB8;
    localparam logic [15:0] FEED_RESET = 16'h0000;
    localparam logic [15:0] SCALE_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] SCALE_ALL_ZEROS = 16'h0000;
    localparam logic [15:0] SCALE_UNITY = 16'h2710;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, 8'hFF, 8'hFF, 16'h0000, 16'hFFFF, 5'h00};
endpackage
`default_nettype wire

//--- tb/mio_plc_model.sv
`default_nettype none
module mio_plc_model (
    input wire logic clk,
    output logic glob_n,
    output logic [7:0] fast_in,
    output logic [7:0] axis_n,
    output logic [7:0] plus_in,
    output logic [7:0] minus_in,
    output logic [15:0] jog_word_n,
    output logic [4:0] misc,
    output logic [127:0] pos_err
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle levels: every inhibit released, override word at its all-ones 0 % code
    initial begin
        {glob_n, fast_in, axis_n, plus_in, minus_in} = {1'b1, 8'hFF, 8'hFF, 8'h00, 8'h00};
        jog_word_n = 16'hFFFF;
        misc = 5'h00;
        pos_err = '0;
    end
    // each change lands just after an edge and then stands, like a scanned output byte
    task automatic set_locks(input logic g, input logic [7:0] f, a, p, m);
        @(posedge clk);
        {glob_n, fast_in, axis_n, plus_in, minus_in} <= {g, f, a, p, m};
    endtask
    task automatic set_jog(input logic [15:0] w);
        @(posedge clk);
        jog_word_n <= w;
    endtask
    // misc order: reset, emergency stop, rewind, clamp wait, program search
    task automatic set_misc(input logic [4:0] v);
        @(posedge clk);
        misc <= v;
    endtask
    task automatic set_pos(input int ax, input logic [15:0] v);
        @(posedge clk);
        pos_err[16*ax+:16] <= v;
    endtask
endmodule // mio_plc_model
`default_nettype wire

//--- tb/test_mio_interlock_top.sv
`default_nettype none
module test_mio_interlock_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK, RESETN, WE_I, STB_I, CYC_I, ACK_O, IRQ_O;
    logic [7:0] ADR_I, AXIS_PLUS_ENABLE, AXIS_MINUS_ENABLE;
    logic [31:0] DAT_I, DAT_O, JOG_FEED_PRODUCT;
    logic [3:0] SEL_I;
    logic [15:0] JOG_SCALE, DIAG_STATUS;
    logic glob_n;
    logic [7:0] fast_in, axis_n, plus_in, minus_in;
    logic [15:0] jog_w;
    logic [4:0] misc;
    logic [127:0] pos_err;
    int miscompares = 0;
    int check_count = 0;
    mio_plc_model plc (.clk(CLK), .glob_n(glob_n), .fast_in(fast_in), .axis_n(axis_n), .plus_in(plus_in),
        .minus_in(minus_in), .jog_word_n(jog_w), .misc(misc), .pos_err(pos_err));
    mio_interlock_top dut (.CLK(CLK), .RESETN(RESETN), .ADR_I(ADR_I), .DAT_I(DAT_I), .WE_I(WE_I), .SEL_I(SEL_I),
        .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .IRQ_O(IRQ_O),
        .GLOBAL_MOTION_INHIBIT_N(glob_n), .FAST_INHIBIT_INPUTS(fast_in), .AXIS_MOTION_INHIBIT_N(axis_n),
        .PLUS_DIRECTION_INHIBIT(plus_in), .MINUS_DIRECTION_INHIBIT(minus_in), .JOG_RATE_SCALE_N_LOW(jog_w[7:0]),
        .JOG_RATE_SCALE_N_HIGH(jog_w[15:8]), .RESET_REQUEST(misc[0]), .EMERGENCY_STOP_REQUEST(misc[1]),
        .REWIND_RESET_REQUEST(misc[2]), .CLAMP_WAIT(misc[3]), .PROGRAM_SEARCH_ACTIVE(misc[4]),
        .POS_ERROR(pos_err), .AXIS_PLUS_ENABLE(AXIS_PLUS_ENABLE), .AXIS_MINUS_ENABLE(AXIS_MINUS_ENABLE),
        .JOG_SCALE(JOG_SCALE), .JOG_FEED_PRODUCT(JOG_FEED_PRODUCT), .DIAG_STATUS(DIAG_STATUS));
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge CLK);
        {ADR_I, WE_I, DAT_I, CYC_I, STB_I} <= {a, w, d, 2'b11};
        do begin
            @(posedge CLK);
            n++;
        end while (ACK_O !== 1'b1 && n < 50);
        q = DAT_O;
        if (n >= 50) begin
            check("bus answer", 32'h1, 32'h0);
        end
        {CYC_I, STB_I, WE_I} <= 3'b000;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(a, 1'b1, d, q);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(a, 1'b0, 32'h0, q);
        check(name, exp, q);
    endtask
    // pins pass two sync stages and one output stage, the product one more
    task automatic settle;
        repeat (6) @(posedge CLK);
        #1;
    endtask
    task automatic t_reset_values;
        rd_chk("select config", mio_pkg::A_CFG, 32'h0);
        rd_chk("in-position width", mio_pkg::A_INPOS, {16'h0, mio_pkg::INPOS_RESET});
        rd_chk("servo gain axis 4", 8'h6C, 32'h0000_0BB8);
        rd_chk("jog feed axis 1", 8'h40, 32'h0);
        wr(mio_pkg::A_AXIS, 32'h0000_0012);
        rd_chk("read-only axis byte", mio_pkg::A_AXIS, 32'h0000_00FF);
        wr(8'h3C, 32'h0000_5555);
        rd_chk("unmapped read", 8'h3C, 32'h0);
    endtask
    task automatic lock_case(input logic [7:0] cfg, input logic g, input logic [7:0] f, a, p, m);
        logic all_stop;
        logic [7:0] ax, pe, me;
        wr(mio_pkg::A_CFG, {24'h0, cfg});
        plc.set_locks(g, f, a, p, m);
        settle();
        all_stop = (!cfg[0] && !g) || (cfg[1] && !f[6]);
        ax = cfg[2] ? 8'h00 : ~a;
        pe = all_stop ? 8'h00 : ~(ax | (cfg[3] ? 8'h00 : p));
        me = all_stop ? 8'h00 : ~(ax | (cfg[3] ? 8'h00 : m));
        check("plus enables", {24'h0, pe}, {24'h0, AXIS_PLUS_ENABLE});
        check("minus enables", {24'h0, me}, {24'h0, AXIS_MINUS_ENABLE});
        check("interlock item", {31'h0, (pe != 8'hFF) || (me != 8'hFF)}, {31'h0, DIAG_STATUS[5]});
    endtask
    task automatic t_interlocks;
        lock_case(8'h00, 1'b1, 8'hFF, 8'hFF, 8'h00, 8'h00);
        lock_case(8'h00, 1'b0, 8'hFF, 8'hFF, 8'h00, 8'h00);
        lock_case(8'h01, 1'b0, 8'hFF, 8'hFF, 8'h00, 8'h00);
        lock_case(8'h00, 1'b1, 8'hBF, 8'hFF, 8'h00, 8'h00);
        lock_case(8'h02, 1'b1, 8'hBF, 8'hFF, 8'h00, 8'h00);
        lock_case(8'h02, 1'b1, 8'h40, 8'hFF, 8'h00, 8'h00);
        lock_case(8'h00, 1'b1, 8'hFF, 8'h7E, 8'h00, 8'h00);
        lock_case(8'h04, 1'b1, 8'hFF, 8'h7E, 8'h00, 8'h00);
        lock_case(8'h00, 1'b1, 8'hFF, 8'hFF, 8'h81, 8'h02);
        lock_case(8'h08, 1'b1, 8'hFF, 8'hFF, 8'h81, 8'h02);
        lock_case(8'h00, 1'b1, 8'hFF, 8'hFF, 8'h00, 8'h00);
    endtask
    task automatic t_jog;
        logic [15:0] words [5] = '{16'hFFFF, 16'h0000, 16'hD8EF, 16'h0001, 16'hFFFE};
        logic [15:0] e;
        wr(8'h48, 32'h0000_0064);
        wr(mio_pkg::A_CTRL, 32'h0000_0002);
        foreach (words[i]) begin
            plc.set_jog(words[i]);
            settle();
            e = (words[i] == 16'hFFFF || words[i] == 16'h0000) ? 16'h0000 : ~words[i];
            check("jog scale", {16'h0, e}, {16'h0, JOG_SCALE});
            check("jog zero item", {31'h0, e == 16'h0}, {31'h0, DIAG_STATUS[13]});
            check("feed product", 32'd100 * {16'h0, e}, JOG_FEED_PRODUCT);
        end
    endtask
    task automatic t_reset_state;
        wr(mio_pkg::A_ISTAT, 32'h0000_000F);
        for (int i = 0; i < 3; i++) begin
            plc.set_misc(5'(1 << i));
            settle();
            check("plus enables held", 32'h0, {24'h0, AXIS_PLUS_ENABLE});
            check("minus enables held", 32'h0, {24'h0, AXIS_MINUS_ENABLE});
            check("reset wait item", 32'h1, {31'h0, DIAG_STATUS[14]});
            check("masked irq", 32'h0, {31'h0, IRQ_O});
            plc.set_misc(5'h00);
            settle();
            check("reset wait cleared", 32'h0, {31'h0, DIAG_STATUS[14]});
        end
        rd_chk("event status", mio_pkg::A_ISTAT, 32'h0000_0004);
        wr(mio_pkg::A_IMASK, 32'h0000_0004);
        settle();
        check("irq raised", 32'h1, {31'h0, IRQ_O});
        wr(mio_pkg::A_ISTAT, 32'h0000_0004);
        settle();
        check("irq cleared", 32'h0, {31'h0, IRQ_O});
    endtask
    task automatic t_diag;
        plc.set_misc(5'h18);
        plc.set_pos(1, 16'h0011);
        settle();
        check("clamp and search items", 32'h0000_9008, {16'h0, DIAG_STATUS & 16'h9008});
        plc.set_pos(1, 16'h0010);
        plc.set_misc(5'h08);
        settle();
        check("in-position at width", 32'h0000_1000, {16'h0, DIAG_STATUS & 16'h9008});
        rd_chk("diag register", mio_pkg::A_DIAG, 32'h0000_1000);
    endtask
    initial begin
        {RESETN, ADR_I, DAT_I, WE_I, STB_I, CYC_I} = '0;
        SEL_I = 4'hF;
        repeat (4) @(posedge CLK);
        RESETN <= 1'b1;
        t_reset_values();
        t_interlocks();
        t_jog();
        t_reset_state();
        t_diag();
        final_report();
    end
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule // test_mio_interlock_top
`default_nettype wire
